// >>> design/eii_top.sv
// external interrupt inputs: dedicated pin, keyboard unit and apb registers
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module eii_top (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [eii_pkg::EII_AW-1:0]  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        ext_irq_pin_n,
    input  wire logic [4:0]                  key_pins_n,
    input  wire logic [4:0]                  port_a_direction,
    input  wire logic                        ext_irq_vec_ack,
    input  wire logic                        key_vec_ack,
    output logic                             ext_irq_req,
    output logic                             key_irq_req,
    output logic      [15:0]                 irq_vector,
    output logic                             cpu_wake,
    output logic                             ext_irq_pin_level,
    output logic      [4:0]                  key_pin_read,
    output logic      [4:0]                  key_pullup_en,
    output logic      [4:0]                  key_force_input
);

    eii_pkg::eii_state_t s;
    eii_pkg::eii_state_t next_s;

    logic        setup;
    logic        wr_fire;
    logic        mapped;
    logic        ext_pin_high;
    logic        ext_fall;
    logic        key_all_high;
    logic        key_fall;
    logic        ext_sw_ack;
    logic        key_sw_ack;
    logic        ext_ack;
    logic        key_ack;
    logic [31:0] rd_word;

    // zero-wait slave: a transfer completes in its first access cycle
    assign pready  = 1'b1;
    assign setup   = psel && !penable;
    assign wr_fire = psel && penable && pwrite;
    assign mapped  = (paddr == eii_pkg::EII_OFS_EXT_SC)
                  || (paddr == eii_pkg::EII_OFS_KEY_SC)
                  || (paddr == eii_pkg::EII_OFS_KEY_EN);

    // second synchroniser stage only; the first is never looked at
    assign ext_pin_high = s.ext.sync[1];
    assign ext_fall     = s.ext.prev_high && !ext_pin_high;
    // pins not enabled count as high, so they never trigger or block
    assign key_all_high = &(s.key_pins | ~s.key_en);
    assign key_fall     = s.key.prev_high && !key_all_high;

    assign ext_sw_ack = wr_fire && (paddr == eii_pkg::EII_OFS_EXT_SC)
                     && pwdata[eii_pkg::EII_BIT_ACK];
    assign key_sw_ack = wr_fire && (paddr == eii_pkg::EII_OFS_KEY_SC)
                     && pwdata[eii_pkg::EII_BIT_ACK];
    assign ext_ack    = ext_irq_vec_ack || ext_sw_ack;
    assign key_ack    = key_vec_ack || key_sw_ack;

    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (paddr)
            eii_pkg::EII_OFS_EXT_SC: begin
                rd_word[eii_pkg::EII_BIT_PEND]  = s.ext.latch;
                rd_word[eii_pkg::EII_BIT_MASK]  = s.ext.mask;
                rd_word[eii_pkg::EII_BIT_LEVEL] = s.ext.level;
            end
            eii_pkg::EII_OFS_KEY_SC: begin
                rd_word[eii_pkg::EII_BIT_PEND]  = s.key.latch;
                rd_word[eii_pkg::EII_BIT_MASK]  = s.key.mask;
                rd_word[eii_pkg::EII_BIT_LEVEL] = s.key.level;
            end
            eii_pkg::EII_OFS_KEY_EN: begin
                rd_word[4:0] = s.key_en;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    always_comb begin
        next_s = s;

        next_s.ext.sync     = {s.ext.sync[0], ext_irq_pin_n};
        next_s.ext.prev_high = ext_pin_high;
        next_s.key_meta     = key_pins_n;
        next_s.key_pins     = s.key_meta;
        next_s.key.prev_high = key_all_high;

        // read data is captured in the setup cycle; ack bits read zero
        if (setup) begin
            next_s.rdata  = pwrite ? 32'h0000_0000 : rd_word;
            next_s.slverr = !mapped;
        end

        if (wr_fire && paddr == eii_pkg::EII_OFS_EXT_SC) begin
            next_s.ext.mask  = pwdata[eii_pkg::EII_BIT_MASK];
            next_s.ext.level = pwdata[eii_pkg::EII_BIT_LEVEL];
        end
        if (wr_fire && paddr == eii_pkg::EII_OFS_KEY_SC) begin
            next_s.key.mask  = pwdata[eii_pkg::EII_BIT_MASK];
            next_s.key.level = pwdata[eii_pkg::EII_BIT_LEVEL];
        end
        if (wr_fire && paddr == eii_pkg::EII_OFS_KEY_EN) begin
            next_s.key_en = pwdata[4:0];
        end

        // dedicated latch; a fresh edge wins over a same-cycle acknowledge
        if (ext_fall) begin
            next_s.ext.latch = 1'b1;
            next_s.ext.acked = 1'b0;
        end else if (!s.ext.level) begin
            if (ext_ack) begin
                next_s.ext.latch = 1'b0;
            end
            next_s.ext.acked = 1'b0;
        end else if (s.ext.latch || !ext_pin_high) begin
            // level mode: need both acknowledge and a high pin, any order
            // a low pin sets an empty latch; an ack then has nothing to clear
            if ((s.ext.acked || ext_ack) && ext_pin_high) begin
                next_s.ext.latch = 1'b0;
                next_s.ext.acked = 1'b0;
            end else begin
                next_s.ext.latch = 1'b1;
                next_s.ext.acked = s.ext.latch
                                && (s.ext.acked || ext_ack);
            end
        end

        // keyboard latch follows the same scheme on the combined pin
        if (key_fall) begin
            next_s.key.latch = 1'b1;
            next_s.key.acked = 1'b0;
        end else if (!s.key.level) begin
            if (key_ack) begin
                next_s.key.latch = 1'b0;
            end
            next_s.key.acked = 1'b0;
        end else if (s.key.latch || !key_all_high) begin
            // any enabled pin low keeps the request present
            if ((s.key.acked || key_ack) && key_all_high) begin
                next_s.key.latch = 1'b0;
                next_s.key.acked = 1'b0;
            end else begin
                next_s.key.latch = 1'b1;
                next_s.key.acked = s.key.latch
                                && (s.key.acked || key_ack);
            end
        end

        // dedicated source is served first when both are unmasked
        if (next_s.ext.latch && !next_s.ext.mask) begin
            next_s.vector = eii_pkg::EII_VEC_EXT;
        end else if (next_s.key.latch && !next_s.key.mask) begin
            next_s.vector = eii_pkg::EII_VEC_KEY;
        end else begin
            next_s.vector = eii_pkg::EII_VEC_NONE;
        end
    end

    // pins reset to the released level so reset itself is no edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s           <= '0;
            s.ext.sync  <= 2'h3;
            s.ext.prev_high <= 1'b1;
            s.key_meta  <= 5'h1F;
            s.key_pins  <= 5'h1F;
            s.key.prev_high <= 1'b1;
            s.key_en    <= eii_pkg::EII_KEY_EN_RST;
            s.vector    <= eii_pkg::EII_VEC_NONE;
        end else begin
            s <= next_s;
        end
    end

    assign prdata            = s.rdata;
    assign pslverr           = s.slverr && psel && penable;
    assign ext_irq_req       = s.ext.latch && !s.ext.mask;
    assign key_irq_req       = s.key.latch && !s.key.mask;
    assign irq_vector        = s.vector;
    // no clock gating here, so the unit keeps running in wait and stop
    assign cpu_wake          = key_irq_req || ext_irq_req;
    assign ext_irq_pin_level = ext_pin_high;
    assign key_pin_read      = s.key_pins & ~port_a_direction;
    assign key_pullup_en     = s.key_en;
    assign key_force_input   = s.key_en;

    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence ext_ack_seen;
        ext_ack && s.ext.level && s.ext.latch && !ext_fall;
    endsequence

    sequence ext_pin_stays_low;
        !ext_pin_high [*2];
    endsequence

    ext_fall_sets_a: assert property (
        ext_fall |=> s.ext.latch && ext_pin_high == 1'b0)
        else $error("dedicated falling edge not latched");

    ext_level_hold_a: assert property (
        ext_ack_seen ##0 ext_pin_stays_low |-> s.ext.latch)
        else $error("level latch dropped while pin low");

    ext_ack_reads0_a: assert property (
        setup && !pwrite && paddr == eii_pkg::EII_OFS_EXT_SC
        |=> prdata[eii_pkg::EII_BIT_ACK] == 1'b0)
        else $error("acknowledge bit read back nonzero");

    ext_edge_clear_a: assert property (
        !s.ext.level && ext_ack && !ext_fall |=> !s.ext.latch)
        else $error("edge mode acknowledge did not clear");

    ext_flag_poll_a: assert property (
        setup && !pwrite && paddr == eii_pkg::EII_OFS_EXT_SC
        |=> prdata[eii_pkg::EII_BIT_PEND] == $past(s.ext.latch))
        else $error("pending flag disagrees with latch");

    ext_mask_gate_a: assert property (
        s.ext.mask |-> !ext_irq_req ##1 (!s.ext.mask || !ext_irq_req))
        else $error("masked dedicated request reached cpu");

    key_edge_block_a: assert property (
        !s.key.level && !s.key.latch && !s.key.prev_high
        |=> !s.key.latch)
        else $error("key latched while another pin low");

    key_level_clear_a: assert property (
        s.key.level && s.key.latch && s.key.acked && key_all_high
        && !key_fall |=> !s.key.latch)
        else $error("key level request not cleared");

    key_vec_only_a: assert property (
        key_vec_ack && !ext_sw_ack && !ext_fall && !s.ext.level
        |=> s.ext.latch == $past(s.ext.latch))
        else $error("key vector fetch touched dedicated latch");

    vector_ext_a: assert property (
        ext_irq_req && !$past(ext_irq_req) |-> irq_vector == 16'hFFFA)
        else $error("dedicated vector not presented");

    key_wake_a: assert property (
        s.key.latch && !s.key.mask |-> cpu_wake && key_irq_req)
        else $error("unmasked key request gave no wake");

    sequence ext_soft_ack;
        ext_sw_ack && !s.ext.level && !ext_fall;
    endsequence

    sequence key_soft_ack;
        key_sw_ack && !s.key.level && !key_fall;
    endsequence

    ext_rearm_a: assert property (
        ext_soft_ack ##1 ext_fall |=> s.ext.latch)
        else $error("edge after acknowledge not latched");

    key_rearm_a: assert property (
        key_soft_ack ##1 key_fall |=> s.key.latch)
        else $error("key edge after acknowledge not latched");

    ext_level_set_a: assert property (
        s.ext.level && !ext_pin_high |=> s.ext.latch)
        else $error("low level did not hold dedicated latch");

    ext_sw_clear_a: assert property (
        ext_soft_ack |=> !s.ext.latch)
        else $error("acknowledge write did not clear latch");

    ext_vec_clear_a: assert property (
        ext_irq_vec_ack && !s.ext.level && !ext_fall |=> !s.ext.latch)
        else $error("vector fetch did not clear latch");

    ext_vec_only_a: assert property (
        ext_irq_vec_ack && !key_vec_ack && !key_sw_ack && !key_fall
        && !s.key.level |=> s.key.latch == $past(s.key.latch))
        else $error("dedicated fetch touched key request");

    ext_mask_write_a: assert property (
        wr_fire && paddr == eii_pkg::EII_OFS_EXT_SC
        |=> s.ext.mask == $past(pwdata[eii_pkg::EII_BIT_MASK]))
        else $error("dedicated mask write lost");

    ext_level_write_a: assert property (
        wr_fire && paddr == eii_pkg::EII_OFS_EXT_SC
        |=> s.ext.level == $past(pwdata[eii_pkg::EII_BIT_LEVEL]))
        else $error("dedicated level select write lost");

    vector_prio_a: assert property (
        ext_irq_req |-> irq_vector == eii_pkg::EII_VEC_EXT)
        else $error("dedicated request shows wrong vector");

    vector_key_a: assert property (
        key_irq_req && !ext_irq_req |-> irq_vector == eii_pkg::EII_VEC_KEY)
        else $error("key request shows wrong vector");

    vector_none_a: assert property (
        !ext_irq_req && !key_irq_req
        |-> irq_vector == eii_pkg::EII_VEC_NONE)
        else $error("vector shown with no request");

    ext_wake_a: assert property (
        ext_irq_req |-> cpu_wake)
        else $error("dedicated request gave no wake");

    key_fall_sets_a: assert property (
        key_fall |=> s.key.latch)
        else $error("key falling edge not latched");

    key_level_set_a: assert property (
        s.key.level && !key_all_high |=> s.key.latch)
        else $error("key request dropped while pin low");

    key_sw_clear_a: assert property (
        key_soft_ack |=> !s.key.latch)
        else $error("key acknowledge write did not clear");

    key_vec_clear_a: assert property (
        key_vec_ack && !s.key.level && !key_fall |=> !s.key.latch)
        else $error("key vector fetch did not clear");

    key_mask_write_a: assert property (
        wr_fire && paddr == eii_pkg::EII_OFS_KEY_SC
        |=> s.key.mask == $past(pwdata[eii_pkg::EII_BIT_MASK]))
        else $error("key mask write lost");

    key_mask_gate_a: assert property (
        s.key.mask |-> !key_irq_req)
        else $error("masked key request reached cpu");

    key_ack_reads0_a: assert property (
        setup && !pwrite && paddr == eii_pkg::EII_OFS_KEY_SC
        |=> prdata[eii_pkg::EII_BIT_ACK] == 1'b0)
        else $error("key acknowledge bit read back nonzero");

    key_flag_poll_a: assert property (
        setup && !pwrite && paddr == eii_pkg::EII_OFS_KEY_SC
        |=> prdata[eii_pkg::EII_BIT_PEND] == $past(s.key.latch))
        else $error("key pending flag disagrees with request");

    key_en_write_a: assert property (
        wr_fire && paddr == eii_pkg::EII_OFS_KEY_EN
        |=> key_pullup_en == $past(pwdata[4:0]))
        else $error("key enable write lost");

    key_force_in_a: assert property (
        key_force_input == key_pullup_en)
        else $error("enabled key pin not forced to input");

    key_read_dir_a: assert property (
        (key_pin_read & port_a_direction) == 5'h00)
        else $error("key pin read while set as output");

    apb_ready_a: assert property (
        psel && penable |-> pready)
        else $error("access cycle without ready");

    apb_slverr_a: assert property (
        psel && penable && !mapped |-> pslverr)
        else $error("unmapped access gave no error");

endmodule // eii_top

`default_nettype wire

// >>> include/eii_pkg.sv
// package: constants, register map and state types for the external interrupt inputs
package eii_pkg;

    localparam int          EII_AW          = 8;
    localparam int          EII_KEYS        = 5;
    localparam logic [7:0]  EII_OFS_EXT_SC  = 8'h00;
    localparam logic [7:0]  EII_OFS_KEY_SC  = 8'h04;
    localparam logic [7:0]  EII_OFS_KEY_EN  = 8'h08;

    // bit positions shared by both status/control registers
    localparam int          EII_BIT_LEVEL   = 0;
    localparam int          EII_BIT_MASK    = 1;
    localparam int          EII_BIT_ACK     = 2;
    localparam int          EII_BIT_PEND    = 3;

    localparam logic [4:0]  EII_KEY_EN_RST  = 5'h00;
    localparam logic [15:0] EII_VEC_EXT     = 16'hFFFA;
    localparam logic [15:0] EII_VEC_KEY     = 16'hFFE0;
    localparam logic [15:0] EII_VEC_NONE    = 16'h0000;

    typedef struct packed {
        logic [1:0]  sync;
        logic        prev_high;
        logic        latch;
        logic        acked;
        logic        mask;
        logic        level;
    } eii_src_t;

    typedef struct packed {
        eii_src_t    ext;
        eii_src_t    key;
        logic [4:0]  key_meta;
        logic [4:0]  key_pins;
        logic [4:0]  key_en;
        logic [31:0] rdata;
        logic        slverr;
        logic [15:0] vector;
    } eii_state_t;

endpackage

// >>> sim/eii_far_side.sv
// far side model: pins with pullups and a cpu that fetches vectors
`timescale 1ns/1ps
`default_nettype none

module eii_far_side (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        pin_low,
    input  wire logic [4:0]  keys_low,
    input  wire logic        fetch_en,
    input  wire logic        ext_irq_req,
    input  wire logic        key_irq_req,
    input  wire logic [15:0] irq_vector,
    output logic             ext_irq_pin_n,
    output logic [4:0]       key_pins_n,
    output var logic         ext_irq_vec_ack,
    output var logic         key_vec_ack
);
    logic [1:0] wait_cnt;
    // released pins sit at the pullup level, never at the last value
    assign ext_irq_pin_n = ~pin_low;
    assign key_pins_n    = ~keys_low;
    // slow core: waits before fetching, so acks never come for free
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_cnt        <= 2'h0;
            ext_irq_vec_ack <= 1'b0;
            key_vec_ack     <= 1'b0;
        end else begin
            ext_irq_vec_ack <= 1'b0;
            key_vec_ack     <= 1'b0;
            if (fetch_en && (ext_irq_req || key_irq_req)) begin
                wait_cnt <= wait_cnt + 2'h1;
                if (wait_cnt == 2'h2) begin
                    wait_cnt        <= 2'h0;
                    ext_irq_vec_ack <= irq_vector == eii_pkg::EII_VEC_EXT;
                    key_vec_ack     <= irq_vector == eii_pkg::EII_VEC_KEY;
                end
            end
        end
    end
endmodule // eii_far_side
`default_nettype wire

// >>> sim/tb_top.sv
// testbench: register and pin scenarios for eii_top
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        pin_low = 1'b0;
    logic        fetch_en = 1'b0;
    logic [4:0]  keys_low = 5'h00;
    logic [4:0]  dir = 5'h00;
    logic [4:0]  en;
    logic [31:0] prdata;
    logic        pready, pslverr, ext_n, ext_ack, key_ack;
    logic        ext_req, key_req, wake, pin_lvl;
    logic [4:0]  key_n, key_rd, pull_en, force_in;
    logic [15:0] vec;
    logic [32:0] exp_q[$];
    int          mismatches = 0;
    int          check_count = 0;

    always #20 pclk = ~pclk;

    eii_top i_eii_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_irq_pin_n(ext_n), .key_pins_n(key_n), .port_a_direction(dir),
        .ext_irq_vec_ack(ext_ack), .key_vec_ack(key_ack),
        .ext_irq_req(ext_req), .key_irq_req(key_req), .irq_vector(vec),
        .cpu_wake(wake), .ext_irq_pin_level(pin_lvl), .key_pin_read(key_rd),
        .key_pullup_en(pull_en), .key_force_input(force_in));

    eii_far_side i_eii_far_side (.pclk(pclk), .presetn(presetn),
        .pin_low(pin_low), .keys_low(keys_low), .fetch_en(fetch_en),
        .ext_irq_req(ext_req), .key_irq_req(key_req), .irq_vector(vec),
        .ext_irq_pin_n(ext_n), .key_pins_n(key_n),
        .ext_irq_vec_ack(ext_ack), .key_vec_ack(key_ack));

    task automatic wrap_up();
        if (mismatches == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic t(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // called just after a rising edge; leaves one idle cycle behind it
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20) mismatches++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d);
        exp_q.push_back({(a > 8'h08) || (a[1:0] != 2'h0), d});
        apb(1'b0, a, 32'h0);
    endtask

    task automatic outs(input logic [18:0] e);
        @(negedge pclk);
        cmp({wake, ext_req, key_req, vec}, e);
        @(posedge pclk);
    endtask

    // results are taken off the queue as each read completes
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            cmp({pslverr, prdata}, exp_q.pop_front());
        end
    end

    initial begin
        void'($urandom(32'h02E1));
        t(6);
        presetn <= 1'b1;
        t(1);
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h0C, 32'h0);
        apb(1'b1, 8'h0C, 32'hFF);
        pin_low <= 1'b1;
        t(6);
        outs({3'b110, 16'hFFFA});
        rd(8'h00, 32'h8);
        apb(1'b1, 8'h00, 32'h4);
        rd(8'h00, 32'h0);
        pin_low <= 1'b0;
        t(4);
        pin_low <= 1'b1;
        t(6);
        rd(8'h00, 32'h8);
        apb(1'b1, 8'h00, 32'h2);
        outs(19'h0);
        rd(8'h00, 32'hA);
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b1, 8'h00, 32'h5);
        rd(8'h00, 32'h9);
        pin_low <= 1'b0;
        t(6);
        rd(8'h00, 32'h1);
        pin_low <= 1'b1;
        t(6);
        pin_low <= 1'b0;
        t(6);
        rd(8'h00, 32'h9);
        apb(1'b1, 8'h00, 32'h4);
        rd(8'h00, 32'h0);
        en = 5'($urandom) | 5'h03;
        dir <= 5'($urandom);
        apb(1'b1, 8'h04, 32'h2);
        apb(1'b1, 8'h08, {27'h0, en});
        apb(1'b1, 8'h04, 32'h6);
        apb(1'b1, 8'h04, 32'h0);
        rd(8'h08, {27'h0, en});
        keys_low <= 5'h01;
        t(6);
        outs({3'b101, 16'hFFE0});
        @(negedge pclk);
        cmp({pull_en, force_in, key_rd}, {en, en, ~5'h01 & ~dir});
        @(posedge pclk);
        apb(1'b1, 8'h04, 32'h4);
        rd(8'h04, 32'h0);
        keys_low <= 5'h03;
        t(6);
        rd(8'h04, 32'h0);
        keys_low <= 5'h00;
        t(6);
        keys_low <= 5'h02;
        t(6);
        rd(8'h04, 32'h8);
        apb(1'b1, 8'h04, 32'h1);
        apb(1'b1, 8'h04, 32'h5);
        rd(8'h04, 32'h9);
        keys_low <= 5'h00;
        t(6);
        rd(8'h04, 32'h1);
        apb(1'b1, 8'h04, 32'h2);
        keys_low <= 5'h01;
        t(6);
        outs(19'h0);
        rd(8'h04, 32'hA);
        apb(1'b1, 8'h04, 32'h0);
        pin_low <= 1'b1;
        t(6);
        outs({3'b111, 16'hFFFA});
        fetch_en <= 1'b1;
        t(3);
        fetch_en <= 1'b0;
        t(2);
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h8);
        fetch_en <= 1'b1;
        t(3);
        fetch_en <= 1'b0;
        t(2);
        rd(8'h04, 32'h0);
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b1, 8'h04, 32'h1);
        pin_low <= 1'b0;
        keys_low <= 5'h00;
        t(4);
        pin_low <= 1'b1;
        keys_low <= 5'h01;
        t(6);
        presetn <= 1'b0;
        t(2);
        presetn <= 1'b1;
        t(1);
        outs(19'h0);
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        wrap_up();
    end

    // the tests need well under a thousand cycles
    initial begin
        t(4000);
        mismatches++;
        wrap_up();
    end
endmodule // tb_top
`default_nettype wire
